/* File: vks_scanner.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - each 1 ms tick advances one digit
// - after twentieth digit counter restarts at first
// - blank low darkens drivers, steps grid
// - blank lasts 200 us, then grid enables
// - count twenty asserts digit scan position seed
// - segment bytes load 120 us after blank
// - write strobe latches byte, address picks latch
// - blank rising edge enables anode outputs
// - patterns stored pre-decoded, only recalled
// - anodes shared, one grid at a time
// - filament 50 kHz square, 40 percent
// - key matrix scanned every 20 ms
// - decoder drives one of nine columns
// - pressed key reads low on its row
// - row buffer enabled only in data phase
// - compare match fires, interval added back
module vks_scanner
    import vks_pkg::*;
#(
    parameter int DIGITS  = NUM_DIGITS,
    parameter int TICK_C  = TICK_CYC,
    parameter int KEY_TCK = KEY_SCAN_TICKS
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // pattern memory write port, pre-decoded cells
    input  wire logic              pat_we,
    input  wire logic [4:0]        pat_addr,
    input  wire vks_cell_t         pat_data,
    // processor bus to segment latches and key buffer
    input  wire logic              segment_write_strobe_n,
    input  wire logic [3:0]        low_address_bits,
    input  wire logic [7:0]        latched_data_bus,
    input  wire logic              key_read_strobe_n,
    input  wire logic              data_valid,
    // key data returned toward the bus
    output logic [7:0]             key_data,
    output logic                   key_data_oe,
    // key matrix
    output logic [KEY_COLS-1:0]    key_col_n,
    input  wire logic [KEY_ROWS-1:0] key_row_n,
    // key scan request and result
    output logic                   key_scan_pulse,
    output vks_key_t               key_event,
    output logic                   key_event_valid,
    // display drive
    output logic [DIGITS-1:0]      digit_grid_lines,
    output logic [15:0]            segment_anode_lines,
    output logic                   decimal_point_anode,
    output logic                   blank_n,
    output logic                   digit_scan_position,
    output logic                   filament_drive
);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,      // waiting for first tick
        ST_BLANK = 2'b01,      // dark, waiting to load
        ST_HOLD  = 2'b10,      // loaded, dark until 200 us
        ST_SHOW  = 2'b11       // digit lit
    } vks_state_t;

    localparam logic [15:0] BLANK_C = 16'(BLANK_CYC);
    localparam logic [15:0] LOAD_C  = 16'(LOAD_CYC);
    localparam logic [11:0] FIL_C   = 12'(FIL_CYC);
    localparam logic [11:0] FIL_H   = 12'(FIL_HIGH_CYC);
    localparam logic [4:0]  LAST_D  = 5'(DIGITS - 1);
    localparam logic [4:0]  KEY_T   = 5'(KEY_TCK - 1);

    // state registers
    vks_state_t            st_r, st_nxt;
    logic [15:0]           ph_r;             // cycles since blank fall
    logic [4:0]            dig_r;            // digit counter
    logic [DIGITS-1:0]     shift_r;          // grid shift register
    logic [7:0]            lat_lo_r;         // low segment latch
    logic [7:0]            lat_hi_r;         // high segment latch
    logic                  lat_dp_r;         // decimal point latch
    logic [15:0]           anode_r;          // enabled anode drive
    logic                  dp_r;
    logic                  en_r;             // drivers enabled
    logic                  seed_r;           // scan position line
    logic [11:0]           fil_r;            // filament divider
    logic                  fil_out_r;
    logic [4:0]            ktick_r;          // ticks toward key scan
    logic [3:0]            kcol_r;           // column under scan
    logic                  kbusy_r;
    logic                  kscan_r;
    vks_key_t              kev_r;
    logic                  kev_v_r;
    logic                  strobe_d_r;       // last write strobe level
    vks_cell_t             pat_mem [0:31];   // pre-decoded cells

    // free-running counter for interval timers
    logic [TIMER_W-1:0]    tmr_r;
    wire                   tick;

    // named decode wires
    wire                   load_now  = (st_r == ST_BLANK) && (ph_r == LOAD_C - 16'h0001);
    wire                   blank_end = (st_r == ST_HOLD) && (ph_r == BLANK_C - 16'h0001);
    wire                   wr_edge   = !segment_write_strobe_n && strobe_d_r;
    wire                   wr_lo     = wr_edge && (low_address_bits[1:0] == 2'h0);
    wire                   wr_hi     = wr_edge && (low_address_bits[1:0] == 2'h1);
    wire                   wr_dp     = wr_edge && (low_address_bits[1:0] == 2'h2);
    wire [4:0]             next_dig  = (dig_r == LAST_D) ? 5'h00 : dig_r + 5'h01;
    // the digit counter already names the new digit when the load falls due
    wire vks_cell_t        next_cell = pat_mem[dig_r];
    wire                   key_tick  = tick && (ktick_r == KEY_T);
    wire [KEY_ROWS-1:0]    row_seen;
    wire                   key_hit   = kbusy_r && (row_seen != {KEY_ROWS{1'b1}});

    // timer base for the scan tick
    vks_interval_timer #(
        .W        (TIMER_W),
        .INTERVAL (TICK_C)
    ) u_tick (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .count    (tmr_r),
        .fire     (tick)
    );

    // key decoder, driven by the internal scan or by the bus address
    wire [3:0] kaddr = kbusy_r ? kcol_r : low_address_bits;
    wire [7:0] kdata;
    vks_key_decoder #(
        .COLS              (KEY_COLS),
        .ROWS              (KEY_ROWS)
    ) u_key (
        .low_address_bits  (kaddr),
        .key_read_strobe_n (key_read_strobe_n),
        .data_valid        (data_valid),
        .col_drive_n       (key_col_n),
        .row_sense_n       (key_row_n),
        .key_data          (kdata),
        .key_data_oe       (key_data_oe)
    );
    assign row_seen = kdata[KEY_ROWS-1:0];

    // scan sequencer next state
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE:  if (tick) st_nxt = ST_BLANK;
            ST_BLANK: if (load_now) st_nxt = ST_HOLD;
            ST_HOLD:  if (blank_end) st_nxt = ST_SHOW;
            ST_SHOW:  if (tick) st_nxt = ST_BLANK;
        endcase
    end

    // outputs from flops, except key_data, key_data_oe and key_col_n, taken from the key decoder
    assign blank_n             = en_r;
    assign digit_grid_lines    = en_r ? shift_r : DIGITS'(GRID_RST);
    assign segment_anode_lines = anode_r;
    assign decimal_point_anode = dp_r;
    assign digit_scan_position = seed_r;
    assign filament_drive      = fil_out_r;
    assign key_data            = kdata;
    assign key_scan_pulse      = kscan_r;
    assign key_event           = kev_r;
    assign key_event_valid     = kev_v_r;

    // pattern memory holds already-decoded cells
    always_ff @(posedge clk_sys) begin
        if (pat_we) begin
            pat_mem[pat_addr] <= pat_data;
        end
    end

    // free-running counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) tmr_r <= '0;
        else        tmr_r <= tmr_r + 32'h00000001;
    end

    // sequencer state and blank phase counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            ph_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            ph_r <= (st_nxt != st_r) && (st_nxt == ST_BLANK) ? 16'h0000 : ph_r + 16'h0001;
        end
    end

    // digit counter, wraps after the twentieth digit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dig_r  <= LAST_D;
            seed_r <= 1'b0;
        end else if (tick && st_r != ST_BLANK && st_r != ST_HOLD) begin
            dig_r  <= next_dig;
            seed_r <= (dig_r == LAST_D);
        end
    end

    // grid shift register steps on blank fall, re-seeded when the digit counter wraps
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= DIGITS'(GRID_RST);
        end else if (tick && st_r != ST_BLANK && st_r != ST_HOLD) begin
            if (dig_r == LAST_D) shift_r <= {{(DIGITS-1){1'b0}}, 1'b1};
            else                 shift_r <= {shift_r[DIGITS-2:0], 1'b0};
        end
    end

    // driver enable: off during blank, on at blank rise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)          en_r <= 1'b0;
        else if (tick)       en_r <= 1'b0;
        else if (blank_end)  en_r <= 1'b1;
    end

    // segment latches: internal load at 120 us, or bus strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lat_lo_r <= 8'h00;
            lat_hi_r <= 8'h00;
            lat_dp_r <= 1'b0;
        end else if (load_now) begin
            lat_lo_r <= next_cell.seg[7:0];
            lat_hi_r <= next_cell.seg[15:8];
            lat_dp_r <= next_cell.dp;
        end else begin
            if (wr_lo) lat_lo_r <= latched_data_bus;
            if (wr_hi) lat_hi_r <= latched_data_bus;
            if (wr_dp) lat_dp_r <= latched_data_bus[0];
        end
    end

    // write strobe level history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) strobe_d_r <= 1'b1;
        else        strobe_d_r <= segment_write_strobe_n;
    end

    // anodes take latch contents on blank rise, dark while blanked
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            anode_r <= SEG_RST;
            dp_r    <= 1'b0;
        end else if (tick) begin
            anode_r <= SEG_RST;
            dp_r    <= 1'b0;
        end else if (blank_end) begin
            anode_r <= {lat_hi_r, lat_lo_r};
            dp_r    <= lat_dp_r;
        end
    end

    // filament divider: 50 kHz, high for 40 percent
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fil_r     <= 12'h000;
            fil_out_r <= 1'b0;
        end else begin
            fil_r     <= (fil_r == FIL_C - 12'h001) ? 12'h000 : fil_r + 12'h001;
            fil_out_r <= (fil_r < FIL_H);
        end
    end

    // key scan cadence, one pass of all columns per 20 ticks
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ktick_r <= 5'h00;
            kscan_r <= 1'b0;
        end else begin
            kscan_r <= key_tick;
            if (tick) ktick_r <= key_tick ? 5'h00 : ktick_r + 5'h01;
        end
    end

    // column walk, one column read per cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            kbusy_r <= 1'b0;
            kcol_r  <= 4'h0;
        end else if (key_tick) begin
            kbusy_r <= 1'b1;
            kcol_r  <= 4'h0;
        end else if (kbusy_r) begin
            kbusy_r <= (kcol_r != 4'(KEY_COLS - 1));
            kcol_r  <= kcol_r + 4'h1;
        end
    end

    // key event report; no key means no report
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            kev_r   <= '0;
            kev_v_r <= 1'b0;
        end else begin
            kev_v_r <= key_hit;
            if (key_hit) begin
                kev_r.col   <= kcol_r;
                kev_r.row_n <= row_seen;
            end
        end
    end
endmodule : vks_scanner
`default_nettype wire

/* File: vks_pkg.sv */
package vks_pkg;
    // system clock rate and the scan timing, in their own units
    localparam int CLK_HZ          = 100_000_000;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TICK_US         = 1000;            // one digit slot
    localparam int BLANK_US        = 200;             // dark time per digit
    localparam int LOAD_US         = 120;             // segment load after blank fall
    localparam int KEY_SCAN_MS     = 20;              // key matrix period
    localparam int FIL_HZ          = 50_000;          // filament square wave
    localparam int FIL_DUTY_PCT    = 40;
    // derived cycle counts
    localparam int TICK_CYC        = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int BLANK_CYC       = BLANK_US * 1000 / CLK_PERIOD_NS;
    localparam int LOAD_CYC        = LOAD_US * 1000 / CLK_PERIOD_NS;
    localparam int KEY_SCAN_TICKS  = KEY_SCAN_MS * 1000 / TICK_US;
    localparam int FIL_CYC         = CLK_HZ / FIL_HZ;
    localparam int FIL_HIGH_CYC    = FIL_CYC * FIL_DUTY_PCT / 100;
    // display and key matrix geometry
    localparam int NUM_DIGITS      = 20;
    localparam int NUM_SEGS        = 16;
    localparam int KEY_COLS        = 9;
    localparam int KEY_ROWS        = 5;
    localparam int NUM_KEYS        = KEY_COLS * KEY_ROWS;
    localparam int TIMER_W         = 32;
    // reset values
    localparam logic [15:0] SEG_RST   = 16'h0000;
    localparam logic [19:0] GRID_RST  = 20'h00000;

    // two-byte pre-decoded segment cell plus decimal point
    typedef struct packed {
        logic        dp;
        logic [15:0] seg;
    } vks_cell_t;

    // one reported key event
    typedef struct packed {
        logic [3:0] col;
        logic [4:0] row_n;
    } vks_key_t;
endpackage : vks_pkg

/* File: vks_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// free-running counter with one interval compare register
module vks_interval_timer
    import vks_pkg::*;
#(
    parameter int W        = TIMER_W,
    parameter int INTERVAL = TICK_CYC
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // free-running count shared by all compare channels
    input  wire logic [W-1:0] count,
    // one-cycle task pulse
    output logic              fire
);
    localparam logic [W-1:0] IVL = W'(INTERVAL);

    logic [W-1:0] cmp_r;       // compare register
    wire          match = (count == cmp_r);

    assign fire = match;

    // on a match the interval is added back, independent of other channels
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmp_r <= IVL;
        end else if (match) begin
            cmp_r <= cmp_r + IVL;
        end
    end
endmodule : vks_interval_timer
`default_nettype wire

/* File: vks_key_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// 4-to-10 active-low column decoder and gated row buffer
module vks_key_decoder
    import vks_pkg::*;
#(
    parameter int COLS = KEY_COLS,
    parameter int ROWS = KEY_ROWS
) (
    // address and strobes
    input  wire logic [3:0]      low_address_bits,
    input  wire logic            key_read_strobe_n,
    input  wire logic            data_valid,
    // matrix
    output logic [COLS-1:0]      col_drive_n,
    input  wire logic [ROWS-1:0] row_sense_n,
    // bus side of the row buffer
    output logic [7:0]           key_data,
    output logic                 key_data_oe
);
    wire [9:0] dec_n;          // full ten outputs of the decoder

    // one low output per address, codes above nine leave all high
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_dec
            assign dec_n[gi] = !(low_address_bits == 4'(gi));
        end
    endgenerate

    assign col_drive_n = dec_n[COLS-1:0];
    // pulled-up rows, closed key reads low on its row bit
    assign key_data    = {{(8-ROWS){1'b1}}, row_sense_n};
    // buffer only during data-valid phase of the bus cycle
    assign key_data_oe = !key_read_strobe_n && data_valid;
endmodule : vks_key_decoder
`default_nettype wire

/* File: vks_scanner_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks on display, filament and key paths
module vks_scanner_assertions
    import vks_pkg::*;
#(
    parameter int DIGITS  = NUM_DIGITS,
    parameter int TICK_C  = TICK_CYC,
    parameter int KEY_TCK = KEY_SCAN_TICKS
) (
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_n,
    // bus and matrix
    input wire logic                key_read_strobe_n,
    input wire logic                data_valid,
    input wire logic [7:0]          key_data,
    input wire logic                key_data_oe,
    input wire logic [KEY_COLS-1:0] key_col_n,
    input wire logic [KEY_ROWS-1:0] key_row_n,
    input wire logic                key_scan_pulse,
    // display drive
    input wire logic [DIGITS-1:0]   digit_grid_lines,
    input wire logic [15:0]         segment_anode_lines,
    input wire logic                blank_n,
    input wire logic                digit_scan_position,
    input wire logic                filament_drive
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [31:0]       blank_cnt_r; // cycles spent blanked
    logic [31:0]       fil_cnt_r;   // cycles filament high
    logic [31:0]       key_cnt_r;   // cycles since last key scan
    logic              key_seen_r;  // one scan already seen
    logic [DIGITS-1:0] cur_grid_r;  // grid lit now
    logic [DIGITS-1:0] last_grid_r; // grid of the previous slot
    // helper counters, last grid copied while blanked
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {blank_cnt_r, fil_cnt_r, key_cnt_r, key_seen_r} <= '0;
            {cur_grid_r, last_grid_r} <= '0;
        end else begin
            blank_cnt_r <= blank_n ? 32'h0 : blank_cnt_r + 32'h1;
            fil_cnt_r   <= filament_drive ? fil_cnt_r + 32'h1 : 32'h0;
            key_cnt_r   <= key_scan_pulse ? 32'h1 : key_cnt_r + 32'h1;
            key_seen_r  <= key_seen_r | key_scan_pulse;
            if (digit_grid_lines != '0) cur_grid_r <= digit_grid_lines;
            if (!blank_n) last_grid_r <= cur_grid_r;
        end
    end
    property p_dark; !blank_n |-> digit_grid_lines == '0 && segment_anode_lines == 16'h0000; endproperty
    a_dark: assert property (p_dark) else $error("drivers lit while blanked");
    property p_one_grid; $onehot0(digit_grid_lines); endproperty
    a_one_grid: assert property (p_one_grid) else $error("two grids lit");
    property p_blank_len;
        $rose(blank_n) && last_grid_r != '0 |-> blank_cnt_r >= BLANK_CYC - 2 && blank_cnt_r <= BLANK_CYC + 2;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blank length wrong");
    property p_step;
        $rose(blank_n) && last_grid_r != '0 |->
            ##[0:1] digit_grid_lines == {last_grid_r[DIGITS-2:0], last_grid_r[DIGITS-1]};
    endproperty
    a_step: assert property (p_step) else $error("grid did not step by one");
    property p_seed; blank_n && digit_grid_lines != '0 |-> digit_scan_position == digit_grid_lines[0]; endproperty
    a_seed: assert property (p_seed) else $error("scan position wrong");
    property p_fil; $fell(filament_drive) |-> fil_cnt_r == FIL_HIGH_CYC; endproperty
    a_fil: assert property (p_fil) else $error("filament high time wrong");
    property p_key_per; key_scan_pulse && key_seen_r |-> key_cnt_r == KEY_TCK * TICK_C; endproperty
    a_key_per: assert property (p_key_per) else $error("key scan period wrong");
    property p_oe; key_data_oe == (!key_read_strobe_n && data_valid); endproperty
    a_oe: assert property (p_oe) else $error("row buffer enable wrong");
    property p_rows; key_data == {3'b111, key_row_n}; endproperty
    a_rows: assert property (p_rows) else $error("row data wrong");
    property p_cols; $onehot0(~key_col_n); endproperty
    a_cols: assert property (p_cols) else $error("two columns driven");
    // main scenarios reached
    c_lit: cover property ($rose(blank_n));
    c_scan: cover property (key_scan_pulse);
    c_read: cover property (key_data_oe);
endmodule : vks_scanner_assertions
bind vks_scanner vks_scanner_assertions #(.DIGITS(DIGITS), .TICK_C(TICK_C), .KEY_TCK(KEY_TCK)) u_chk (
    .clk_sys, .rst_n, .key_read_strobe_n, .data_valid, .key_data, .key_data_oe, .key_col_n,
    .key_row_n, .key_scan_pulse, .digit_grid_lines, .segment_anode_lines, .blank_n,
    .digit_scan_position, .filament_drive);
`default_nettype wire

/* File: vks_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// key matrix behind the panel, one key held by the bench
module vks_panel_model
    import vks_pkg::*;
(
    // columns from the scanner
    input wire logic [KEY_COLS-1:0] key_col_n,
    // key held closed
    input wire logic                press_en,
    input wire logic [3:0]          press_col,
    input wire logic [2:0]          press_row,
    // pulled-up rows
    output logic [KEY_ROWS-1:0]     key_row_n
);
    // contact conducts only while its column is pulled low
    wire logic hit = press_en && press_col < 4'(KEY_COLS) && !key_col_n[press_col];
    // rows rest at the pull-up level
    assign key_row_n = hit ? ~(KEY_ROWS'(1) << press_row) : '1;
endmodule : vks_panel_model
`default_nettype wire

/* File: vks_scanner_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// display slots, segment writes and key reads
module vks_scanner_tb_top
    import vks_pkg::*;
;
    localparam int DIG = 2;     // short frame keeps the wrap in reach
    localparam int TCK = 20500; // tick above the fixed blank time
    localparam int KTK = 2;     // key scan every second tick
    localparam int LIMIT = 95000;
    // bench drive
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic pat_we = 1'b0;
    logic [4:0] pat_addr = 5'h00;
    vks_cell_t pat_data = '0;
    logic segment_write_strobe_n = 1'b1;
    logic [3:0] low_address_bits = 4'h0;
    logic [7:0] latched_data_bus = 8'h00;
    logic key_read_strobe_n = 1'b1;
    logic data_valid = 1'b0;
    logic [3:0] press_col = 4'h4; // key held at column 4, row 2
    // design outputs
    logic [7:0] key_data;
    logic key_data_oe, key_scan_pulse, key_event_valid;
    logic [KEY_COLS-1:0] key_col_n;
    logic [KEY_ROWS-1:0] key_row_n;
    vks_key_t key_event, ev_last;
    logic [DIG-1:0] digit_grid_lines;
    logic [15:0] segment_anode_lines;
    logic decimal_point_anode, blank_n, digit_scan_position, filament_drive;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int ev_cnt = 0;
    int pulse_cnt = 0;
    vks_cell_t pat [DIG] = '{'{1'b1, 16'hA55A}, '{1'b0, 16'h0FF1}};
    vks_scanner #(.DIGITS(DIG), .TICK_C(TCK), .KEY_TCK(KTK)) dut (
        .clk_sys, .rst_n, .pat_we, .pat_addr, .pat_data, .segment_write_strobe_n,
        .low_address_bits, .latched_data_bus, .key_read_strobe_n, .data_valid, .key_data,
        .key_data_oe, .key_col_n, .key_row_n, .key_scan_pulse, .key_event, .key_event_valid,
        .digit_grid_lines, .segment_anode_lines, .decimal_point_anode, .blank_n,
        .digit_scan_position, .filament_drive);
    vks_panel_model u_panel (.key_col_n, .press_en(1'b1), .press_col, .press_row(3'h2),
        .key_row_n);
    always #5 clk_sys = ~clk_sys;
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // hang guard, key events taken as the processor would
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (key_scan_pulse === 1'b1) pulse_cnt++;
        if (key_event_valid === 1'b1) begin
            ev_cnt++;
            ev_last = key_event;
        end
        if (cyc == LIMIT) begin
            num_errors++;
            results();
        end
    end
    // dark outputs in reset, then pattern memory load
    task automatic t_reset();
        repeat (10) @(negedge clk_sys);
        chk("rst", {blank_n, digit_grid_lines, segment_anode_lines, filament_drive}, 0);
        rst_n = 1'b1;
        for (int d = 0; d < DIG; d++) begin
            @(negedge clk_sys) {pat_we, pat_addr, pat_data} = {1'b1, 5'(d), pat[d]};
        end
        @(negedge clk_sys) pat_we = 1'b0;
    endtask : t_reset
    // every bus column, buffer only in the data phase
    task automatic t_keys();
        key_read_strobe_n = 1'b0;
        for (int a = 0; a < 10; a++) begin
            @(negedge clk_sys) {low_address_bits, data_valid} = {4'(a), 1'b0};
            #1 chk("oe_idle", key_data_oe, 0);
            @(negedge clk_sys) data_valid = 1'b1;
            #1 chk("oe", key_data_oe, 1);
            chk("col", key_col_n, a < 9 ? 9'(~(9'h1 << a)) : 9'h1FF);
            chk("rows", key_data, a == 4 ? 8'hFB : 8'hFF);
        end
        @(negedge clk_sys) {key_read_strobe_n, data_valid} = 2'b10;
    endtask : t_keys
    // one bus byte into a segment latch
    task automatic t_wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys) {low_address_bits, latched_data_bus} = {a, d};
        segment_write_strobe_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        segment_write_strobe_n = 1'b1;
        @(negedge clk_sys);
    endtask : t_wr
    // one digit slot from blank to lit, bus bytes written in its hold window if asked
    task automatic t_slot(input int k, input bit bus);
        int n;
        n = 0;
        while (k > 0 && blank_n !== 1'b0 && n < TCK + 100) begin
            @(posedge clk_sys) n++;
        end
        #1 chk("dark", {digit_grid_lines, segment_anode_lines}, 0);
        if (bus) t_seg();
        n = 0;
        while (blank_n !== 1'b1 && n < TCK + 25000) begin
            @(posedge clk_sys) n++;
        end
        repeat (2) @(negedge clk_sys);
        chk("grid", digit_grid_lines, 1 << (k % DIG));
        chk("seg", segment_anode_lines, bus ? 16'h3CA5 : pat[k % DIG].seg);
        chk("dp", decimal_point_anode, bus ? 1'b1 : pat[k % DIG].dp);
        chk("seed", digit_scan_position, k % DIG == 0);
    endtask : t_slot
    // bus bytes after the internal load land in the latches, shown at blank rise
    task automatic t_seg();
        repeat (LOAD_CYC + 8) @(negedge clk_sys);
        t_wr(4'h0, 8'hA5);
        t_wr(4'h1, 8'h3C);
        t_wr(4'h2, 8'h01);
        t_wr(4'h3, 8'hFF);
        while (blank_n !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        chk("bus_seg", segment_anode_lines, 16'h3CA5);
        chk("bus_dp", decimal_point_anode, 1);
    endtask : t_seg
    // main sequence
    initial begin
        t_reset();
        t_keys();
        t_slot(0, 1'b0);
        t_slot(1, 1'b1);
        t_slot(2, 1'b0);
        // let the second key scan and its event pass
        repeat (600) @(negedge clk_sys);
        chk("scans", pulse_cnt, 2);
        chk("events", ev_cnt, pulse_cnt);
        chk("event", ev_last, {4'h4, 5'h1B});
        results();
    end
endmodule : vks_scanner_tb_top
`default_nettype wire
